// >>> logic/nv_access_pkg.sv
package nv_access_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_OFS   = 8'h00;
  localparam logic [7:0] DATA_OFS   = 8'h04;
  localparam logic [7:0] CTRL_OFS   = 8'h08;
  localparam logic [7:0] STAT_OFS   = 8'h0C;
  localparam logic [7:0] MASK_OFS   = 8'h10;
  localparam logic [7:0] SYS_OFS    = 8'h14;

  // Control register bit positions
  localparam int RD_STROBE_BIT = 0;
  localparam int WR_BUSY_BIT   = 1;
  localparam int ARM_BIT       = 2;
  localparam int RIE_BIT       = 3;

  // System register bit positions
  localparam int GIE_BIT       = 0;
  localparam int PD_REQ_BIT    = 1;

  // Status and mask bit positions
  localparam int EV_WR_DONE    = 0;
  localparam int EV_RD_DONE    = 1;

  localparam int NV_AW         = 9;
  localparam int NV_DW         = 8;
  localparam int NV_DEPTH      = 512;

  localparam logic [8:0] ADDR_RST = 9'h000;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] EV_RST   = 2'h0;

  // Timing
  localparam int CLK_MHZ        = 20;
  localparam int WRITE_TIME_US  = 8448;
  localparam int WRITE_CYCLES   = WRITE_TIME_US * CLK_MHZ;
  localparam logic [2:0] ARM_CYCLES   = 3'h4;
  localparam logic [2:0] RD_STALL     = 3'h4;
  localparam logic [2:0] WR_STALL     = 3'h2;

  typedef struct packed {
    logic             wr_en;
    logic             rd_en;
    logic [NV_AW-1:0] addr;
    logic [NV_DW-1:0] wdata;
  } mem_req_t;

  typedef enum logic [1:0] {OP_NONE, OP_READ, OP_WRITE} op_t;

endpackage

// >>> logic/nv_array.sv
`timescale 1ns/1ns
module nv_array
(
  input  wire logic                  pclk,
  input  wire nv_access_pkg::mem_req_t req,
  output logic [nv_access_pkg::NV_DW-1:0] rdata_r
);

  logic [nv_access_pkg::NV_DW-1:0] cells [nv_access_pkg::NV_DEPTH];

  // No reset: contents are nonvolatile
  always_ff @(posedge pclk)
  begin
    if (req.wr_en)
      cells[req.addr] <= req.wdata;
  end

  always_ff @(posedge pclk)
  begin
    if (req.rd_en)
      rdata_r <= cells[req.addr];
  end

endmodule

// >>> logic/eeprom_access_control.sv
// Functional notes
// - Write launches only when arm is set before the strobe.
// - Valid strobe programs the selected address with data register.
// - Read strobe puts addressed byte in data register for next access.
// - Fetched byte is returned through the data register.
// - Power-down entry does not stop an active programming cycle.
// - Write finishing in power-down keeps oscillator running.
// - Reset does not abort programming while supply is sufficient.
// - Arm clears itself after four cycles; later strobes do nothing.
// - Busy stays set for the whole timed write, then clears.
// - Ready interrupt is a level while enabled and busy is clear.
// - Read strobe stalls the bus four cycles, write strobe two.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ns
module eeprom_access_control
#(
  parameter int WRITE_CYCLES = nv_access_pkg::WRITE_CYCLES
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        supply_ok_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             irq,
  output logic             osc_hold_r,
  output logic             full_power_down_r
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [8:0]              addr_r;
  logic [7:0]              data_r;
  logic                    rie_r;
  logic                    arm_r;
  logic [2:0]              arm_cnt_r;
  logic [1:0]              stat_r;
  logic [1:0]              mask_r;
  logic                    gie_r;
  logic                    pd_req_r;
  logic                    busy_r;
  logic [31:0]             prog_cnt_r;
  logic [8:0]              prog_addr_r;
  logic [7:0]              prog_data_r;
  logic                    wr_done;
  nv_access_pkg::op_t      op_r;
  logic [2:0]              stall_r;
  logic                    acc;
  logic                    acc_first;
  logic                    done;
  logic                    wr_ctrl;
  nv_access_pkg::op_t      op_nxt;
  logic [7:0]              mem_q;
  nv_access_pkg::mem_req_t mreq;
  logic                    rd_done_r;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, nv_access_pkg::ADDR_OFS) | hit(a, nv_access_pkg::DATA_OFS)
           | hit(a, nv_access_pkg::CTRL_OFS) | hit(a, nv_access_pkg::STAT_OFS)
           | hit(a, nv_access_pkg::MASK_OFS) | hit(a, nv_access_pkg::SYS_OFS);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // APB access phase and strobe stall

  assign acc       = psel & penable;
  assign wr_ctrl   = acc & pwrite & hit(paddr, nv_access_pkg::CTRL_OFS);
  assign acc_first = wr_ctrl & (op_r == nv_access_pkg::OP_NONE)
                   & (stall_r == 3'h0);

  // Strobe decision is taken on the first access cycle, so an arm that
  // times out during the stall still launches the write.
  always_comb
  begin
    op_nxt = nv_access_pkg::OP_NONE;
    if (acc_first)
    begin
      if (pwdata[nv_access_pkg::WR_BUSY_BIT] & arm_r & ~busy_r)
        op_nxt = nv_access_pkg::OP_WRITE;
      else if (pwdata[nv_access_pkg::RD_STROBE_BIT] & ~busy_r)
        op_nxt = nv_access_pkg::OP_READ;
    end
  end

  always_comb
  begin
    case (op_r)
      nv_access_pkg::OP_NONE:  pready = (op_nxt == nv_access_pkg::OP_NONE);
      nv_access_pkg::OP_READ:  pready = (stall_r == 3'h1);
      nv_access_pkg::OP_WRITE: pready = (stall_r == 3'h1);
      default:                 pready = 1'b1;
    endcase
  end

  assign done    = acc & pready;
  assign pslverr = acc & ~mapped(paddr);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_r    <= nv_access_pkg::OP_NONE;
      stall_r <= 3'h0;
    end
    else if (done)
    begin
      op_r    <= nv_access_pkg::OP_NONE;
      stall_r <= 3'h0;
    end
    else if (op_nxt == nv_access_pkg::OP_READ)
    begin
      op_r    <= op_nxt;
      stall_r <= nv_access_pkg::RD_STALL;
    end
    else if (op_nxt == nv_access_pkg::OP_WRITE)
    begin
      op_r    <= op_nxt;
      stall_r <= nv_access_pkg::WR_STALL;
    end
    else if (stall_r != 3'h0)
      stall_r <= stall_r - 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Array port: read issued at stall start, data ready long before done

  always_comb
  begin
    mreq       = '0;
    mreq.rd_en = (op_nxt == nv_access_pkg::OP_READ);
    mreq.addr  = mreq.rd_en ? addr_r : prog_addr_r;
    mreq.wdata = prog_data_r;
    mreq.wr_en = wr_done;
  end

  nv_array u_array
  (
    .pclk    (pclk),
    .req     (mreq),
    .rdata_r (mem_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address and data registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      addr_r <= nv_access_pkg::ADDR_RST;
    else if (done & pwrite & hit(paddr, nv_access_pkg::ADDR_OFS) & ~busy_r)
      addr_r <= pwdata[8:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      data_r <= nv_access_pkg::DATA_RST;
    else if (done & (op_r == nv_access_pkg::OP_READ))
      data_r <= mem_q;
    else if (done & pwrite & hit(paddr, nv_access_pkg::DATA_OFS))
      data_r <= pwdata[7:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Control: ready enable and self-clearing arm

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rie_r <= 1'b0;
    else if (done & wr_ctrl)
      rie_r <= pwdata[nv_access_pkg::RIE_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      arm_r     <= 1'b0;
      arm_cnt_r <= 3'h0;
    end
    else if (done & wr_ctrl & pwdata[nv_access_pkg::ARM_BIT])
    begin
      arm_r     <= 1'b1;
      arm_cnt_r <= nv_access_pkg::ARM_CYCLES;
    end
    else if (arm_cnt_r == 3'h1)
    begin
      arm_r     <= 1'b0;
      arm_cnt_r <= 3'h0;
    end
    else if (arm_cnt_r != 3'h0)
      arm_cnt_r <= arm_cnt_r - 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Programming engine: reset only by loss of supply, so a bus reset
  // never cuts a write short. Sleep requests are not looked at here.

  assign wr_done = busy_r & (prog_cnt_r == 32'h1);

  always_ff @(posedge pclk or negedge supply_ok_n)
  begin
    if (!supply_ok_n)
    begin
      busy_r      <= 1'b0;
      prog_cnt_r  <= 32'h0;
      prog_addr_r <= 9'h000;
      prog_data_r <= 8'h00;
    end
    else if (~busy_r & done & (op_r == nv_access_pkg::OP_WRITE))
    begin
      busy_r      <= 1'b1;
      prog_cnt_r  <= WRITE_CYCLES;
      prog_addr_r <= addr_r;
      prog_data_r <= data_r;
    end
    else if (wr_done)
    begin
      busy_r     <= 1'b0;
      prog_cnt_r <= 32'h0;
    end
    else if (busy_r)
      prog_cnt_r <= prog_cnt_r - 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Events, mask, system control and interrupt

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_done_r <= 1'b0;
    else
      rd_done_r <= done & (op_r == nv_access_pkg::OP_READ);
  end

  // A new event in the clearing read's cycle survives the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_r <= nv_access_pkg::EV_RST;
    else
      stat_r <= (stat_r
                & ~{2{done & ~pwrite & hit(paddr, nv_access_pkg::STAT_OFS)}})
                | {rd_done_r, wr_done};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_r   <= nv_access_pkg::EV_RST;
      gie_r    <= 1'b0;
      pd_req_r <= 1'b0;
    end
    else if (done & pwrite)
    begin
      if (hit(paddr, nv_access_pkg::MASK_OFS))
        mask_r <= pwdata[1:0];
      if (hit(paddr, nv_access_pkg::SYS_OFS))
      begin
        gie_r    <= pwdata[nv_access_pkg::GIE_BIT];
        pd_req_r <= pwdata[nv_access_pkg::PD_REQ_BIT];
      end
    end
  end

  assign irq = (|(stat_r & mask_r))
             | (rie_r & gie_r & ~busy_r);

  // Power-down is only complete once no write ran into it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_hold_r        <= 1'b0;
      full_power_down_r <= 1'b0;
    end
    else
    begin
      if (~pd_req_r)
        osc_hold_r <= 1'b0;
      else if (wr_done)
        osc_hold_r <= 1'b1;
      full_power_down_r <= pd_req_r & ~busy_r & ~osc_hold_r & ~wr_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb
  begin
    prdata = 32'h0;
    case (paddr)
      nv_access_pkg::ADDR_OFS: prdata[8:0] = addr_r;
      nv_access_pkg::DATA_OFS: prdata[7:0] = data_r;
      nv_access_pkg::CTRL_OFS: prdata[3:0] = {rie_r, arm_r, busy_r, 1'b0};
      nv_access_pkg::STAT_OFS: prdata[1:0] = stat_r;
      nv_access_pkg::MASK_OFS: prdata[1:0] = mask_r;
      nv_access_pkg::SYS_OFS:  prdata[1:0] = {pd_req_r, gie_r};
      default:                 prdata = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb_pos @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_arm_times_out: assert property (
    $rose(arm_r) |-> arm_r [*4] ##1 (!arm_r || $past(done)))
    else $error("arm did not clear after four cycles");

  a_rd_stall_len: assert property (
    (op_nxt == nv_access_pkg::OP_READ) |-> !pready [*4] ##1 pready)
    else $error("read strobe stall is not four cycles");

  a_wr_stall_len: assert property (
    (op_nxt == nv_access_pkg::OP_WRITE) |-> !pready [*2] ##1 pready)
    else $error("write strobe stall is not two cycles");

  a_launch_needs_arm: assert property (
    $rose(busy_r) |-> $past(op_r) == nv_access_pkg::OP_WRITE)
    else $error("write launched without armed strobe");

  a_busy_no_arm: assert property (
    (acc_first && pwdata[1] && !arm_r) |=> !$rose(busy_r))
    else $error("strobe without arm started a write");

  a_read_data: assert property (
    (op_nxt == nv_access_pkg::OP_READ) |-> ##5 (data_r == $past(mem_q)))
    else $error("read byte not in data register");

  a_busy_held: assert property (
    disable iff (!supply_ok_n) $rose(busy_r) |-> busy_r [*8])
    else $error("busy dropped early");

  a_addr_frozen: assert property (
    (busy_r && $past(busy_r)) |-> $stable(addr_r))
    else $error("address changed during programming");

  a_ready_irq: assert property (
    (rie_r && gie_r && !busy_r) |-> irq)
    else $error("ready interrupt not asserted");

  a_osc_hold: assert property (
    (wr_done && pd_req_r) |=> osc_hold_r ##1 !full_power_down_r)
    else $error("oscillator not held after write in power-down");

endmodule

// >>> verification/eeprom_access_control_tb.sv
`timescale 1ns/1ns
module eeprom_access_control_tb;
  localparam int         WC    = 20;
  localparam logic [7:0] A_ADR = nv_access_pkg::ADDR_OFS;
  localparam logic [7:0] A_DAT = nv_access_pkg::DATA_OFS;
  localparam logic [7:0] A_CTL = nv_access_pkg::CTRL_OFS;
  localparam logic [7:0] A_STA = nv_access_pkg::STAT_OFS;
  localparam logic [7:0] A_MSK = nv_access_pkg::MASK_OFS;
  localparam logic [7:0] A_SYS = nv_access_pkg::SYS_OFS;

  logic        pclk;
  logic        presetn;
  logic        supply_ok_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        osc_hold;
  logic        fpd;
  logic [31:0] rv;
  logic [31:0] lfsr;
  logic        er;
  logic [8:0]  a;
  logic [7:0]  d;
  int          n_mismatch;
  int          checks;
  int          w;

  eeprom_access_control #(.WRITE_CYCLES(WC)) uut
  (
    .pclk              (pclk),
    .presetn           (presetn),
    .supply_ok_n       (supply_ok_n),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .pready            (pready),
    .prdata            (prdata),
    .pslverr           (pslverr),
    .irq               (irq),
    .osc_hold_r        (osc_hold),
    .full_power_down_r (fpd)
  );

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction

  task automatic summarize;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks: the request stays up until the bus ends; idle releases it

  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] dt);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= dt;
    w = -1;
    @(posedge pclk);
    penable <= 1'b1;
    // Read before the edge's updates land, as the slave sees them
    do
    begin
      @(posedge pclk);
      w++;
    end
    while (pready !== 1'b1 && w < 40);
    if (pready !== 1'b1)
      chk("pready", 32'h1, {31'h0, pready});
    rv = prdata;
    er = pslverr;
  endtask

  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask

  task automatic look(input logic ei, input logic ef, input logic eo);
    @(negedge pclk);
    chk("irq", {31'h0, ei}, {31'h0, irq});
    chk("full_power_down", {31'h0, ef}, {31'h0, fpd});
    chk("osc_hold", {31'h0, eo}, {31'h0, osc_hold});
    @(posedge pclk);
  endtask

  task automatic poll;
    int k;
    k = 0;
    do
    begin
      apb(1'b0, A_CTL, 32'h0);
      k++;
    end
    while (rv[1] !== 1'b0 && k < 60);
    chk("busy_clear", 32'h0, {31'h0, rv[1]});
  endtask

  task automatic launch(input logic [8:0] ad, input logic [7:0] dt,
                        input logic [31:0] ex);
    poll;
    apb(1'b1, A_ADR, {23'h0, ad});
    apb(1'b1, A_DAT, {24'h0, dt});
    apb(1'b1, A_CTL, 32'h4 | ex);
    apb(1'b1, A_CTL, 32'h2 | ex);
    chk("write_stall", 32'h2, w);
    apb(1'b0, A_CTL, 32'h0);
    chk("busy_set", 32'h1, {31'h0, rv[1]});
  endtask

  task automatic fetch(input logic [8:0] ad, input logic [7:0] dt);
    poll;
    apb(1'b1, A_ADR, {23'h0, ad});
    apb(1'b1, A_CTL, 32'h1);
    chk("read_stall", 32'h4, w);
    apb(1'b0, A_DAT, 32'h0);
    chk("read_data", {24'h0, dt}, rv);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs a few hundred cycles

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    summarize;
  end

  initial
  begin
    presetn = 1'b0;
    supply_ok_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lfsr = 32'h1733;
    n_mismatch = 0;
    checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    supply_ok_n <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset_value", 32'h0, rv);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_data", 32'h0, rv);
    // Corner addresses first, then random ones
    for (int i = 0; i < 4; i++)
    begin
      lfsr = nxt(lfsr);
      a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : lfsr[8:0];
      d = lfsr[15:8];
      launch(a, d, 32'h0);
      apb(1'b1, A_ADR, {23'h0, ~a});
      apb(1'b0, A_ADR, 32'h0);
      chk("addr_locked", {23'h0, a}, rv);
      apb(1'b1, A_CTL, 32'h1);
      chk("busy_read_stall", 32'h0, w);
      poll;
      apb(1'b0, A_STA, 32'h0);
      chk("status", (i == 0) ? 32'h1 : 32'h3, rv);
      fetch(a, d);
    end
    apb(1'b1, A_CTL, 32'h4);
    idle(5);
    apb(1'b1, A_CTL, 32'h2);
    chk("late_strobe", 32'h0, w);
    apb(1'b0, A_CTL, 32'h0);
    chk("late_busy", 32'h0, {31'h0, rv[1]});
    apb(1'b1, A_CTL, 32'h2);
    chk("bare_strobe", 32'h0, w);
    apb(1'b0, A_STA, 32'h0);
    chk("status_rd", 32'h2, rv);
    // Masked event interrupt, cleared by reading status
    apb(1'b1, A_MSK, 32'h1);
    launch(9'h055, 8'hA5, 32'h0);
    poll;
    idle(2);
    look(1'b1, 1'b0, 1'b0);
    apb(1'b0, A_STA, 32'h0);
    idle(1);
    look(1'b0, 1'b0, 1'b0);
    // Ready level interrupt and power-down during a write
    apb(1'b1, A_MSK, 32'h0);
    poll;
    apb(1'b1, A_SYS, 32'h3);
    apb(1'b1, A_CTL, 32'h8);
    idle(1);
    look(1'b1, 1'b1, 1'b0);
    launch(9'h0AA, 8'h3C, 32'h8);
    idle(1);
    look(1'b0, 1'b0, 1'b0);
    poll;
    idle(1);
    look(1'b1, 1'b0, 1'b1);
    apb(1'b1, A_SYS, 32'h0);
    apb(1'b1, A_CTL, 32'h0);
    fetch(9'h0AA, 8'h3C);
    // Bus reset in mid-write must leave the programming cycle running
    launch(9'h123, 8'h5A, 32'h0);
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_CTL, 32'h0);
    chk("busy_kept", 32'h1, {31'h0, rv[1]});
    poll;
    fetch(9'h123, 8'h5A);
    idle(1);
    summarize;
  end
endmodule
